// >>> verilog/mrdc_top.sv
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mrdc_map.svh"
module mrdc_top #(
    parameter int OVC_CYC = `MRDC_OVC_CYC,
    parameter int KEY_CYC = `MRDC_KEY_DGL_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Analog sense inputs
    input wire logic key_on,
    input wire logic battery_supply_ok,
    input wire logic overtemp,
    input wire logic overcurrent,
    // Relay drive and interrupt
    output logic main_relay_drive,
    output logic relay_overcurrent_flag,
    output logic irq
);
    localparam int OVC_MAX_CYC = `MRDC_OVC_MAX_NS / `MRDC_CLK_NS;
    if (OVC_CYC < 1 || OVC_CYC > OVC_MAX_CYC) begin : g_ovc_chk
        $error("overcurrent filter length out of range");
    end

    typedef struct packed {
        logic [1:0] ot_s;
        logic [1:0] oc_s;
        logic [1:0] bat_s;
        logic key_prev;
        logic [7:0] oc_cnt;
        mrdc_pkg::mrdc_state_e st;
        logic latched;
        logic retried;
        logic latch_dis;
        logic latch_en;
        logic react;
        logic [`MRDC_EV_W-1:0] evt;
        logic [`MRDC_EV_W-1:0] mask;
        logic ap_v;
        logic ap_w;
        logic [7:0] ap_a;
        logic [31:0] rdata;
        logic drive;
        logic flag;
        logic irq;
    } mrdc_s;

    mrdc_s q, d;
    logic key_f;

    mrdc_deglitch #(
        .CYC(KEY_CYC)
    ) u_key (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(key_on),
        .filt(key_f)
    );

    function automatic logic [31:0] status_word(input mrdc_s s, input logic k);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`MRDC_STAT_OUT_BIT] = s.drive;
        w[`MRDC_STAT_OVC_BIT] = s.flag;
        w[`MRDC_STAT_OT_BIT] = s.st == mrdc_pkg::MRDC_OT_OFF;
        w[`MRDC_STAT_KEY_BIT] = k;
        w[`MRDC_STAT_BAT_BIT] = s.bat_s[1];
        return w;
    endfunction

    logic ot, oc, bat, key_fall, oc_trip, want_on;
    logic wr, rd_irq;
    logic [`MRDC_EV_W-1:0] ev_set;

    always_comb begin
        ot = q.ot_s[1];
        oc = q.oc_s[1];
        bat = q.bat_s[1];
        key_fall = q.key_prev && !key_f;
        oc_trip = oc && (q.oc_cnt == 8'(OVC_CYC - 1));
        // Power latch: hold on after key off while the host asks for it
        want_on = key_f || (!q.latch_dis && q.latch_en);
        wr = q.ap_v && q.ap_w;
        rd_irq = q.ap_v && !q.ap_w && q.ap_a == `MRDC_IRQ_OFS;
        ev_set = '0;
        d = q;
        // Sense inputs come from the analog side: two flops before use
        d.ot_s = {q.ot_s[0], overtemp};
        d.oc_s = {q.oc_s[0], overcurrent};
        d.bat_s = {q.bat_s[0], battery_supply_ok};
        // Resets low like the idle key, so no false fall after reset
        d.key_prev = key_f;
        d.react = 1'b0;
        // Filter counter restarts whenever the comparator releases
        if (!oc || q.st != mrdc_pkg::MRDC_ON) begin
            d.oc_cnt = 8'h00;
        end else if (!oc_trip) begin
            d.oc_cnt = q.oc_cnt + 8'h01;
        end
        unique case (q.st)
            mrdc_pkg::MRDC_OFF: begin
                if (want_on && !q.latched) begin
                    d.st = mrdc_pkg::MRDC_ON;
                end
            end
            mrdc_pkg::MRDC_ON: begin
                if (oc_trip) begin
                    d.st = mrdc_pkg::MRDC_OVC_OFF;
                    d.oc_cnt = 8'h00;
                    ev_set[`MRDC_EV_OVC_BIT] = 1'b1;
                    // Without battery, or after the one retry: latch
                    d.latched = !bat || q.retried;
                end else if (bat && ot) begin
                    d.st = mrdc_pkg::MRDC_OT_OFF;
                    ev_set[`MRDC_EV_OT_BIT] = 1'b1;
                end else if (!want_on) begin
                    d.st = mrdc_pkg::MRDC_OFF;
                end
            end
            mrdc_pkg::MRDC_OT_OFF: begin
                if (!ot || !bat) begin
                    d.st = want_on ? mrdc_pkg::MRDC_ON
                                   : mrdc_pkg::MRDC_OFF;
                end
            end
            mrdc_pkg::MRDC_OVC_OFF: begin
                if (!q.latched && bat && q.react) begin
                    d.st = mrdc_pkg::MRDC_ON;
                end else if (!q.latched && !bat && !q.retried) begin
                    d.st = mrdc_pkg::MRDC_ON;
                    d.retried = 1'b1;
                end else if (!q.latched && !bat) begin
                    d.latched = 1'b1;
                end
            end
        endcase
        if (key_fall) begin
            d.latched = 1'b0;
            d.retried = 1'b0;
            if (q.st == mrdc_pkg::MRDC_OVC_OFF) begin
                d.st = mrdc_pkg::MRDC_OFF;
            end
            ev_set[`MRDC_EV_KEY_BIT] = 1'b1;
        end
        // A clean on phase at good battery rearms the single retry
        if (q.st == mrdc_pkg::MRDC_ON && bat && !oc) begin
            d.retried = 1'b0;
        end
        // Register writes
        if (wr && q.ap_a == `MRDC_CTRL_OFS) begin
            d.latch_dis = hwdata[`MRDC_CTRL_LDIS_BIT];
            d.latch_en = hwdata[`MRDC_CTRL_LATCH_BIT];
            d.react = hwdata[`MRDC_CTRL_REACT_BIT];
        end
        if (wr && q.ap_a == `MRDC_MASK_OFS) begin
            d.mask = hwdata[`MRDC_EV_W-1:0];
        end
        // Read clears, but a new event in the same cycle survives
        d.evt = (rd_irq ? '0 : q.evt) | ev_set;
        // Address phase capture
        d.ap_v = hsel && hready && htrans[1];
        d.ap_w = hwrite;
        d.ap_a = {haddr[7:2], 2'b00};
        d.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case ({haddr[7:2], 2'b00})
                `MRDC_CTRL_OFS: d.rdata = {29'h0, q.react, q.latch_en,
                                           q.latch_dis};
                `MRDC_STAT_OFS: d.rdata = status_word(q, key_f);
                `MRDC_IRQ_OFS: d.rdata = {29'h0, q.evt};
                `MRDC_MASK_OFS: d.rdata = {29'h0, q.mask};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        d.drive = d.st == mrdc_pkg::MRDC_ON;
        d.flag = d.st == mrdc_pkg::MRDC_OVC_OFF;
        // Level interrupt: high while an unmasked sticky event is set
        d.irq = |(d.evt & d.mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.st <= mrdc_pkg::MRDC_OFF;
            q.mask <= `MRDC_MASK_RST;
        end else begin
            q <= d;
        end
    end

    assign hrdata = q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign main_relay_drive = q.drive;
    assign relay_overcurrent_flag = q.flag;
    assign irq = q.irq;

    // Assertions
    property p_flag_off;
        @(posedge hclk) disable iff (!hresetn)
        relay_overcurrent_flag |-> !main_relay_drive;
    endproperty
    AST_FLAG_OFF: assert property (p_flag_off)
        else $error("flag high while relay on");
    AST_OVC_FILTER: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(q.flag) |-> $past(q.oc_cnt) == 8'(OVC_CYC - 1))
        else $error("overcurrent acted before filter time");
    AST_CNT_RESTART: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !q.oc_s[1] |=> q.oc_cnt == 8'h00)
        else $error("filter counter not restarted");
    AST_LATCH_HOLD: assert property (
        @(posedge hclk) disable iff (!hresetn)
        q.latched && !key_fall |=> !main_relay_drive)
        else $error("latched output turned on");
    AST_KEY_CLEAR: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(q.latched) |-> $past(key_fall))
        else $error("latch cleared without key falling");
    AST_OT_OFF: assert property (
        @(posedge hclk) disable iff (!hresetn)
        q.st == mrdc_pkg::MRDC_ON && q.bat_s[1] && q.ot_s[1]
        && !oc_trip |=> !main_relay_drive)
        else $error("overtemperature ignored");
    AST_REACT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(main_relay_drive) && $past(q.st) == mrdc_pkg::MRDC_OVC_OFF
        |-> $past(q.bat_s[1]) || q.retried)
        else $error("reactivation at low battery");
    AST_LDIS_TRACK: assert property (
        @(posedge hclk) disable iff (!hresetn)
        q.latch_dis && !key_f && q.st == mrdc_pkg::MRDC_ON |=> !q.drive)
        else $error("output held with latch disabled");
    AST_DRIVE_CAUSE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(main_relay_drive) |-> !$past(q.latched))
        else $error("output on while latched");

    // Tracking, overtemperature and retry
    AST_KEY_TRACK: assert property (
        @(posedge hclk) disable iff (!hresetn)
        q.latch_dis && key_f && q.st == mrdc_pkg::MRDC_OFF && !q.latched
        |=> main_relay_drive)
        else $error("relay not following key");

    AST_OT_BACK: assert property (
        @(posedge hclk) disable iff (!hresetn)
        q.st == mrdc_pkg::MRDC_OT_OFF && !q.ot_s[1] && key_f
        |=> main_relay_drive)
        else $error("relay not back after cooling");

    AST_OT_NOBAT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        q.st == mrdc_pkg::MRDC_ON && !q.bat_s[1] && want_on && !oc_trip
        |=> main_relay_drive)
        else $error("relay dropped without battery");

    AST_NOBAT_LATCH: assert property (
        @(posedge hclk) disable iff (!hresetn)
        oc_trip && q.st == mrdc_pkg::MRDC_ON && !q.bat_s[1] && !key_fall
        |=> q.latched)
        else $error("trip without battery not latched");

    AST_REACT_LOW: assert property (
        @(posedge hclk) disable iff (!hresetn)
        q.st == mrdc_pkg::MRDC_OVC_OFF && q.react && !q.bat_s[1] && q.retried
        |=> !main_relay_drive)
        else $error("reactivate honoured at low battery");

    AST_RETRY_ONCE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        q.st == mrdc_pkg::MRDC_OVC_OFF && !q.bat_s[1] && !q.latched
        && !q.retried && !key_fall |=> main_relay_drive)
        else $error("automatic retry missing");

    AST_RETRY_LATCH: assert property (
        @(posedge hclk) disable iff (!hresetn)
        oc_trip && q.st == mrdc_pkg::MRDC_ON && q.retried && !key_fall
        |=> q.latched)
        else $error("second trip not latched");

    // Flag, filter and events
    AST_FLAG_SET: assert property (
        @(posedge hclk) disable iff (!hresetn)
        oc_trip && q.st == mrdc_pkg::MRDC_ON
        |=> relay_overcurrent_flag)
        else $error("flag not set on trip");

    AST_FLAG_CLEAR: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(relay_overcurrent_flag)
        |-> main_relay_drive || $past(key_fall))
        else $error("flag cleared while output still off");

    AST_CNT_STEP: assert property (
        @(posedge hclk) disable iff (!hresetn)
        q.st == mrdc_pkg::MRDC_ON && q.oc_s[1] && !oc_trip
        |=> q.oc_cnt == $past(q.oc_cnt) + 8'h01)
        else $error("filter counter did not advance");

    AST_EV_OVC: assert property (
        @(posedge hclk) disable iff (!hresetn)
        oc_trip && q.st == mrdc_pkg::MRDC_ON
        |=> q.evt[`MRDC_EV_OVC_BIT])
        else $error("overcurrent event lost");

    AST_EV_KEY: assert property (
        @(posedge hclk) disable iff (!hresetn)
        key_fall
        |=> q.evt[`MRDC_EV_KEY_BIT])
        else $error("key falling event lost");

    AST_RD_CLEAR: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_irq && !(|ev_set)
        |=> !(|q.evt))
        else $error("event register not cleared by read");

    COV_OVC: cover property (@(posedge hclk) $rose(relay_overcurrent_flag));
    COV_OT: cover property (@(posedge hclk) q.st == mrdc_pkg::MRDC_OT_OFF);
    COV_RETRY: cover property (@(posedge hclk) $rose(q.retried));
    COV_KEYCLR: cover property (@(posedge hclk) $fell(q.latched));
    COV_LATCH: cover property (@(posedge hclk)
        !key_f && q.latch_en && main_relay_drive);
endmodule

// >>> verilog/mrdc_map.svh
`ifndef MRDC_MAP_SVH
`define MRDC_MAP_SVH
// Register byte offsets
`define MRDC_CTRL_OFS 8'h00
`define MRDC_STAT_OFS 8'h04
`define MRDC_IRQ_OFS 8'h08
`define MRDC_MASK_OFS 8'h0C
// Control fields
`define MRDC_CTRL_LDIS_BIT 0
`define MRDC_CTRL_LATCH_BIT 1
`define MRDC_CTRL_REACT_BIT 2
// Status fields
`define MRDC_STAT_OUT_BIT 0
`define MRDC_STAT_OVC_BIT 1
`define MRDC_STAT_OT_BIT 2
`define MRDC_STAT_KEY_BIT 3
`define MRDC_STAT_BAT_BIT 4
// Interrupt events
`define MRDC_EV_OVC_BIT 0
`define MRDC_EV_OT_BIT 1
`define MRDC_EV_KEY_BIT 2
`define MRDC_EV_W 3
// Reset values
`define MRDC_CTRL_RST 3'h0
`define MRDC_MASK_RST 3'h0
// Timing: filter window in ns, clock period in ns
`define MRDC_CLK_NS 50
`define MRDC_OVC_MIN_NS 5250
`define MRDC_OVC_MAX_NS 8750
`define MRDC_OVC_CYC ((`MRDC_OVC_MIN_NS + `MRDC_CLK_NS - 1) / `MRDC_CLK_NS)
`define MRDC_KEY_DGL_CYC 16
`endif

// >>> verilog/mrdc_pkg.sv
package mrdc_pkg;
    typedef enum logic [1:0] {
        MRDC_OFF,
        MRDC_ON,
        MRDC_OT_OFF,
        MRDC_OVC_OFF
    } mrdc_state_e;
endpackage

// >>> verilog/mrdc_deglitch.sv
`timescale 1ns/1ps
`include "mrdc_map.svh"
module mrdc_deglitch #(
    parameter int CYC = `MRDC_KEY_DGL_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Raw and filtered level
    input wire logic raw,
    output logic filt
);
    if (CYC < 2 || CYC > 65535) begin : g_cyc_chk
        $error("deglitch length out of range");
    end
    typedef struct packed {
        logic s1;
        logic s2;
        logic lvl;
        logic [15:0] cnt;
    } mrdc_dgl_s;
    mrdc_dgl_s q, d;
    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        if (q.s2 == q.lvl) begin
            d.cnt = 16'h0000;
        end else if (q.cnt == 16'(CYC - 1)) begin
            d.lvl = q.s2;
            d.cnt = 16'h0000;
        end else begin
            d.cnt = q.cnt + 16'h0001;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign filt = q.lvl;

    AST_DGL_HOLD: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $changed(q.lvl) |-> $past(q.cnt) == 16'(CYC - 1))
        else $error("filtered key moved before the deglitch time");
endmodule

// >>> bench/mrdc_coil_model.sv
`timescale 1ns/1ps
module mrdc_coil_model (
    // Drive from the block and injected fault
    input wire logic drive,
    input wire logic shorted,
    // Current comparator seen by the block
    output logic overcurrent
);
    // Coil current passes the limit only while driven into a short
    assign overcurrent = drive & shorted;
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "mrdc_map.svh"
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hready, hreadyout, hresp, overcurrent, drive, flag, irq;
    logic key_on = 1'b0;
    logic bat = 1'b0;
    logic overtemp = 1'b0;
    logic shorted = 1'b0;
    int n_mismatch = 0;
    int total_checks = 0;

    always #25 hclk = ~hclk;
    assign hready = hreadyout;

    mrdc_top #(.OVC_CYC(10), .KEY_CYC(4)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .key_on(key_on),
        .battery_supply_ok(bat), .overtemp(overtemp),
        .overcurrent(overcurrent), .main_relay_drive(drive),
        .relay_overcurrent_flag(flag), .irq(irq)
    );

    mrdc_coil_model i_coil (
        .drive(drive), .shorted(shorted), .overcurrent(overcurrent)
    );

    task results;
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for the slave's ready at each phase, bounded
    task wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            results();
        end
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsize <= 3'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task wait_drive(input logic v);
        int k;
        k = 0;
        while (drive !== v && k < 300) begin
            @(posedge hclk);
            k++;
        end
        chk({31'h0, drive}, {31'h0, v});
        if (drive !== v)
            results();
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({29'h0, drive, flag, irq}, 32'h0);
        rdc(`MRDC_CTRL_OFS, {29'h0, `MRDC_CTRL_RST});
        rdc(`MRDC_MASK_OFS, {29'h0, `MRDC_MASK_RST});
        rdc(8'h10, 32'h0);
        // Plain key tracking, glitch on key ignored
        bat <= 1'b1;
        bus(1'b1, `MRDC_CTRL_OFS, 32'h1);
        key_on <= 1'b1;
        wait_drive(1'b1);
        key_on <= 1'b0;
        repeat (2) @(posedge hclk);
        key_on <= 1'b1;
        repeat (20) @(posedge hclk);
        chk({31'h0, drive}, 32'h1);
        key_on <= 1'b0;
        wait_drive(1'b0);
        // Power latch holds the relay after key off
        bus(1'b1, `MRDC_CTRL_OFS, 32'h2);
        key_on <= 1'b1;
        wait_drive(1'b1);
        key_on <= 1'b0;
        repeat (30) @(posedge hclk);
        chk({31'h0, drive}, 32'h1);
        key_on <= 1'b1;
        repeat (20) @(posedge hclk);
        // Overtemperature off and recovery, interrupt masked then cleared
        overtemp <= 1'b1;
        wait_drive(1'b0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `MRDC_MASK_OFS, 32'h2);
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, `MRDC_IRQ_OFS, 32'h0);
        chk({31'h0, rd[`MRDC_EV_OT_BIT]}, 32'h1);
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        overtemp <= 1'b0;
        wait_drive(1'b1);
        // Short overcurrent bursts restart the filter
        repeat (3) begin
            shorted <= 1'b1;
            repeat (5) @(posedge hclk);
            shorted <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        repeat (10) @(posedge hclk);
        chk({30'h0, drive, flag}, 32'h2);
        shorted <= 1'b1;
        wait_drive(1'b0);
        chk({31'h0, flag}, 32'h1);
        rdc(`MRDC_STAT_OFS, 32'h1A);
        rdc(`MRDC_IRQ_OFS, 32'h1);
        chk({31'h0, hresp}, 32'h0);
        // Host reactivation with battery present
        shorted <= 1'b0;
        bus(1'b1, `MRDC_CTRL_OFS, 32'h6);
        wait_drive(1'b1);
        chk({31'h0, flag}, 32'h0);
        // Battery low: one retry, then latched until key falls
        shorted <= 1'b1;
        wait_drive(1'b0);
        bat <= 1'b0;
        wait_drive(1'b1);
        wait_drive(1'b0);
        repeat (100) @(posedge hclk);
        chk({30'h0, drive, flag}, 32'h1);
        shorted <= 1'b0;
        bus(1'b1, `MRDC_CTRL_OFS, 32'h6);
        repeat (30) @(posedge hclk);
        chk({31'h0, drive}, 32'h0);
        key_on <= 1'b0;
        repeat (40) @(posedge hclk);
        key_on <= 1'b1;
        bat <= 1'b1;
        wait_drive(1'b1);
        chk({31'h0, flag}, 32'h0);
        // Host drops only the relay: key off, then power latch released
        key_on <= 1'b0;
        repeat (20) @(posedge hclk);
        chk({31'h0, drive}, 32'h1);
        bus(1'b1, `MRDC_CTRL_OFS, 32'h0);
        wait_drive(1'b0);
        rdc(`MRDC_STAT_OFS, 32'h10);
        results();
    end
endmodule
